// >>> rtl/bxa_xor_alu.sv
// Exclusive-OR execution datapath with AHB-Lite register access
//
// Design decisions made here: the address map and the AHB-Lite register port.
`include "bxa_consts.svh"
`default_nettype none
module bxa_xor_alu #(
    parameter int NREG = 28,
    parameter int AW   = 5
) (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o
);
    bxa_pkg::bxa_state_t state_ff, nxt_state;
    logic [7:0]    addr_ff, nxt_addr;
    logic          map_ff, nxt_map;
    logic          wr_pend_ff, nxt_wr_pend;
    logic          rd_pend_ff, nxt_rd_pend;
    logic          hready_ff, nxt_hready;
    logic [31:0]   hrdata_ff, nxt_hrdata;
    logic          hresp_ff;
    logic          sat_mode_ff, nxt_sat_mode;
    logic          c_ff, v_ff, z_ff, n_ff, unf_ff, lovf_ff, lunf_ff, err_ff;
    logic          nxt_c, nxt_v, nxt_z, nxt_n, nxt_unf, nxt_lovf, nxt_lunf, nxt_err;
    logic [31:0]   instr_ff, nxt_instr;
    logic [31:0]   opnd_a_ff, nxt_opnd_a;
    logic [31:0]   opnd_b_ff, nxt_opnd_b;
    logic [31:0]   idx_a_ff, nxt_idx_a;
    logic [31:0]   idx_b_ff, nxt_idx_b;
    logic [31:0]   result_ff, nxt_result;
    logic [31:0]   disp_ff, nxt_disp;
    logic [AW-1:0] rf_addr_ff, nxt_rf_addr;
    logic          rf_we;
    logic [AW-1:0] rf_waddr;
    logic [31:0]   rf_wdata;

    logic          acc_w, wr_cmt_w, three_w, bad_w, exec_w;
    logic [1:0]    mode_w, type_w, dsel_w;
    logic [AW-1:0] dst_w, src1_w, src2_w;
    logic [31:0]   op1_w, op2_w, res_w, disp_w, stat_w, rd_mux_w;

    bxa_rf_if #(.AW(AW), .DW(32)) rf_bus ();

    bxa_regfile #(.NREG(NREG), .AW(AW), .DW(32)) u_regfile (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .rf     (rf_bus.mem)
    );

    // ==========================================================
    // Instruction fields
    assign three_w = instr_ff[`BXA_IN_FORM];
    assign mode_w  = instr_ff[`BXA_IN_MODE +: 2];
    assign type_w  = instr_ff[`BXA_IN_TYPE +: 2];
    assign dst_w   = instr_ff[`BXA_IN_DST +: AW];
    assign src1_w  = instr_ff[`BXA_IN_SRC1 +: AW];
    assign src2_w  = instr_ff[`BXA_IN_SRC2 +: AW];
    assign dsel_w  = instr_ff[`BXA_IN_DSEL +: 2];

    // Any register index past the file is refused
    assign bad_w = (int'(dst_w) >= NREG)
                || (!three_w && mode_w == `BXA_MODE_REG && int'(src1_w) >= NREG)
                || (three_w && !type_w[`BXA_TYPE_S1_IND] && int'(src1_w) >= NREG)
                || (three_w && !type_w[`BXA_TYPE_S2_IND] && int'(src2_w) >= NREG);
    assign exec_w = (state_ff == bxa_pkg::ST_EXEC) && !bad_w;

    // ==========================================================
    // Operand select and result
    assign rf_bus.rd_a_addr = (state_ff == bxa_pkg::ST_IDLE) ? rf_addr_ff
                            : (three_w ? src1_w : dst_w);
    assign rf_bus.rd_b_addr = three_w ? src2_w : src1_w;

    always_comb
    begin
        op1_w = rf_bus.rd_a_data;
        if (three_w && type_w[`BXA_TYPE_S1_IND])
            op1_w = opnd_a_ff;
        if (three_w)
            op2_w = type_w[`BXA_TYPE_S2_IND] ? opnd_b_ff : rf_bus.rd_b_data;
        else
        begin
            unique case (mode_w)
                `BXA_MODE_REG: op2_w = rf_bus.rd_b_data;
                `BXA_MODE_DIR: op2_w = opnd_a_ff;
                `BXA_MODE_IND: op2_w = opnd_a_ff;
                `BXA_MODE_IMM: op2_w = {16'h0000, opnd_a_ff[15:0]};
            endcase
        end
        res_w = op1_w ^ op2_w;
        unique case (dsel_w)
            `BXA_DSEL_ZERO: disp_w = 32'h0000_0000;
            `BXA_DSEL_ONE:  disp_w = 32'h0000_0001;
            `BXA_DSEL_IDXA: disp_w = idx_a_ff;
            default:        disp_w = idx_b_ff;
        endcase
    end

    // ==========================================================
    // Read data mux
    always_comb
    begin
        stat_w               = `BXA_RST_WORD;
        stat_w[`BXA_ST_C]    = c_ff;
        stat_w[`BXA_ST_V]    = v_ff;
        stat_w[`BXA_ST_Z]    = z_ff;
        stat_w[`BXA_ST_N]    = n_ff;
        stat_w[`BXA_ST_UNF]  = unf_ff;
        stat_w[`BXA_ST_LOVF] = lovf_ff;
        stat_w[`BXA_ST_LUNF] = lunf_ff;
        stat_w[`BXA_ST_ERR]  = err_ff;
        rd_mux_w             = `BXA_RST_WORD;
        if (map_ff)
        begin
            case (addr_ff)
                `BXA_OFF_CTRL:    rd_mux_w[`BXA_CTRL_SAT] = sat_mode_ff;
                `BXA_OFF_STATUS:  rd_mux_w = stat_w;
                `BXA_OFF_INSTR:   rd_mux_w = instr_ff;
                `BXA_OFF_OPND_A:  rd_mux_w = opnd_a_ff;
                `BXA_OFF_OPND_B:  rd_mux_w = opnd_b_ff;
                `BXA_OFF_IDX_A:   rd_mux_w = idx_a_ff;
                `BXA_OFF_IDX_B:   rd_mux_w = idx_b_ff;
                `BXA_OFF_RESULT:  rd_mux_w = result_ff;
                `BXA_OFF_DISP:    rd_mux_w = disp_ff;
                `BXA_OFF_RF_ADDR: rd_mux_w[AW-1:0] = rf_addr_ff;
                `BXA_OFF_RF_DATA: rd_mux_w = rf_bus.rd_a_data;
                default:          rd_mux_w = `BXA_RST_WORD;
            endcase
        end
    end

    // ==========================================================
    // Next state: bus, registers and execute sequencing
    assign acc_w    = hsel_i && htrans_i[1] && hready_i;
    assign wr_cmt_w = wr_pend_ff && hready_ff;

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_addr    = addr_ff;
        nxt_map     = map_ff;
        nxt_wr_pend = wr_pend_ff;
        nxt_rd_pend = rd_pend_ff;
        nxt_hrdata  = hrdata_ff;
        nxt_sat_mode = sat_mode_ff;
        {nxt_c, nxt_v, nxt_z, nxt_n} = {c_ff, v_ff, z_ff, n_ff};
        {nxt_unf, nxt_lovf, nxt_lunf, nxt_err} = {unf_ff, lovf_ff, lunf_ff, err_ff};
        nxt_instr   = instr_ff;
        nxt_opnd_a  = opnd_a_ff;
        nxt_opnd_b  = opnd_b_ff;
        nxt_idx_a   = idx_a_ff;
        nxt_idx_b   = idx_b_ff;
        nxt_result  = result_ff;
        nxt_disp    = disp_ff;
        nxt_rf_addr = rf_addr_ff;
        rf_we       = 1'b0;
        rf_waddr    = dst_w;
        rf_wdata    = res_w;

        if (wr_cmt_w)
        begin
            nxt_wr_pend = 1'b0;
            if (map_ff)
            begin
                case (addr_ff)
                    `BXA_OFF_CTRL:    nxt_sat_mode = hwdata_i[`BXA_CTRL_SAT];
                    `BXA_OFF_STATUS:
                    begin
                        nxt_c    = hwdata_i[`BXA_ST_C];
                        nxt_v    = hwdata_i[`BXA_ST_V];
                        nxt_z    = hwdata_i[`BXA_ST_Z];
                        nxt_n    = hwdata_i[`BXA_ST_N];
                        nxt_unf  = hwdata_i[`BXA_ST_UNF];
                        nxt_lovf = hwdata_i[`BXA_ST_LOVF];
                        nxt_lunf = hwdata_i[`BXA_ST_LUNF];
                        nxt_err = err_ff && !hwdata_i[`BXA_ST_ERR];
                    end
                    `BXA_OFF_INSTR:
                    begin
                        nxt_instr = hwdata_i;
                        nxt_state = bxa_pkg::ST_FETCH;
                    end
                    `BXA_OFF_OPND_A:  nxt_opnd_a = hwdata_i;
                    `BXA_OFF_OPND_B:  nxt_opnd_b = hwdata_i;
                    `BXA_OFF_IDX_A:   nxt_idx_a  = hwdata_i;
                    `BXA_OFF_IDX_B:   nxt_idx_b  = hwdata_i;
                    `BXA_OFF_RF_ADDR: nxt_rf_addr = hwdata_i[AW-1:0];
                    `BXA_OFF_RF_DATA:
                    begin
                        rf_we    = int'(rf_addr_ff) < NREG;
                        rf_waddr = rf_addr_ff;
                        rf_wdata = hwdata_i;
                    end
                    default:          nxt_wr_pend = 1'b0;
                endcase
            end
        end

        unique case (state_ff)
            bxa_pkg::ST_IDLE:
                if (rd_pend_ff)
                    nxt_state = bxa_pkg::ST_RDOUT;
            bxa_pkg::ST_FETCH:
                nxt_state = bxa_pkg::ST_EXEC;
            bxa_pkg::ST_EXEC:
            begin
                nxt_state = bxa_pkg::ST_IDLE;
                if (bad_w)
                    nxt_err = 1'b1;
                else
                begin
                    rf_we      = 1'b1;
                    nxt_result = res_w;
                    nxt_n      = res_w[31];
                    nxt_z      = (res_w == 32'h0000_0000);
                    nxt_v      = 1'b0;
                    nxt_unf    = 1'b0;
                    if (three_w && type_w != 2'h0)
                        nxt_disp = disp_w;
                end
            end
            bxa_pkg::ST_RDOUT:
            begin
                nxt_state   = bxa_pkg::ST_IDLE;
                nxt_rd_pend = 1'b0;
                nxt_hrdata  = rd_mux_w;
            end
        endcase

        if (acc_w)
        begin
            nxt_addr = haddr_i[7:0];
            nxt_map  = (haddr_i[31:8] == 24'h00_0000);
            if (hwrite_i)
                nxt_wr_pend = 1'b1;
            else
                nxt_rd_pend = 1'b1;
        end
        nxt_hready = (nxt_state == bxa_pkg::ST_IDLE) && !nxt_rd_pend;
    end

    assign rf_bus.wr_en   = rf_we;
    assign rf_bus.wr_addr = rf_waddr;
    assign rf_bus.wr_data = rf_wdata;

    // ==========================================================
    // State registers
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            state_ff   <= bxa_pkg::ST_IDLE;
            addr_ff    <= 8'h00;
            map_ff     <= 1'b0;
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            hready_ff  <= 1'b1;
            hrdata_ff  <= `BXA_RST_WORD;
            hresp_ff   <= 1'b0;
            sat_mode_ff <= 1'b0;
            {c_ff, v_ff, z_ff, n_ff} <= 4'h0;
            {unf_ff, lovf_ff, lunf_ff, err_ff} <= 4'h0;
            instr_ff   <= `BXA_RST_WORD;
            opnd_a_ff  <= `BXA_RST_WORD;
            opnd_b_ff  <= `BXA_RST_WORD;
            idx_a_ff   <= `BXA_RST_WORD;
            idx_b_ff   <= `BXA_RST_WORD;
            result_ff  <= `BXA_RST_WORD;
            disp_ff    <= `BXA_RST_WORD;
            rf_addr_ff <= {AW{1'b0}};
        end
        else
        begin
            state_ff   <= nxt_state;
            addr_ff    <= nxt_addr;
            map_ff     <= nxt_map;
            wr_pend_ff <= nxt_wr_pend;
            rd_pend_ff <= nxt_rd_pend;
            hready_ff  <= nxt_hready;
            hrdata_ff  <= nxt_hrdata;
            hresp_ff   <= 1'b0;
            sat_mode_ff <= nxt_sat_mode;
            {c_ff, v_ff, z_ff, n_ff} <= {nxt_c, nxt_v, nxt_z, nxt_n};
            {unf_ff, lovf_ff, lunf_ff, err_ff} <= {nxt_unf, nxt_lovf, nxt_lunf, nxt_err};
            instr_ff   <= nxt_instr;
            opnd_a_ff  <= nxt_opnd_a;
            opnd_b_ff  <= nxt_opnd_b;
            idx_a_ff   <= nxt_idx_a;
            idx_b_ff   <= nxt_idx_b;
            result_ff  <= nxt_result;
            disp_ff    <= nxt_disp;
            rf_addr_ff <= nxt_rf_addr;
        end
    end

    assign hrdata_o    = hrdata_ff;
    assign hreadyout_o = hready_ff;
    assign hresp_o     = hresp_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    two_op_write_a: assert property (exec_w && !three_w |-> rf_we && rf_waddr == dst_w
        ##1 result_ff == ($past(rf_bus.rd_a_data) ^ $past(op2_w))) else $error("two-operand result wrong");
    imm_unsigned_a: assert property (exec_w && !three_w && mode_w == `BXA_MODE_IMM
        |=> result_ff[31:16] == $past(rf_bus.rd_a_data[31:16])) else $error("immediate extended");
    nz_flags_a: assert property (exec_w |=> n_ff == result_ff[31] && z_ff == (result_ff == 0)
        && !v_ff && !unf_ff) else $error("flag update wrong");
    kept_flags_a: assert property (exec_w |=> $stable(c_ff) && $stable(lovf_ff)
        && $stable(lunf_ff)) else $error("kept flag changed");
    sat_ignored_a: assert property (exec_w && sat_mode_ff |=> !v_ff
        && result_ff == ($past(op1_w) ^ $past(op2_w))) else $error("saturate mode took effect");
    three_op_write_a: assert property (exec_w && three_w |-> rf_we && rf_waddr == dst_w
        ##1 result_ff == ($past(op1_w) ^ $past(op2_w))) else $error("three-operand result wrong");
    src1_type_a: assert property (state_ff == bxa_pkg::ST_FETCH && three_w
        && !type_w[0] |-> rf_bus.rd_a_addr == src1_w ##1 op1_w == rf_bus.rd_a_data)
        else $error("first source type wrong");
    src2_type_a: assert property (state_ff == bxa_pkg::ST_FETCH && three_w
        && !type_w[1] |-> rf_bus.rd_b_addr == src2_w ##1 op2_w == rf_bus.rd_b_data)
        else $error("second source type wrong");
    disp_range_a: assert property (exec_w && three_w && type_w != 2'h0 |=> disp_ff <= 32'h0000_0001
        || disp_ff == idx_a_ff || disp_ff == idx_b_ff) else $error("bad displacement");
    reg_range_a: assert property (rf_we |-> int'(rf_waddr) < NREG)
        else $error("register index out of range");
    mode_reg_a: assert property (state_ff == bxa_pkg::ST_FETCH && !three_w
        && mode_w == `BXA_MODE_REG |-> rf_bus.rd_b_addr == src1_w ##1 op2_w == rf_bus.rd_b_data)
        else $error("register source not used");
    one_cycle_a: assert property (state_ff == bxa_pkg::ST_FETCH |=> state_ff == bxa_pkg::ST_EXEC
        ##1 state_ff != bxa_pkg::ST_EXEC) else $error("execute not one cycle");
endmodule : bxa_xor_alu
`default_nettype wire

// >>> rtl/bxa_consts.svh
// Constants for the exclusive-OR execution block
`ifndef BXA_CONSTS_SVH
`define BXA_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define BXA_OFF_CTRL     8'h00
`define BXA_OFF_STATUS   8'h04
`define BXA_OFF_INSTR    8'h08
`define BXA_OFF_OPND_A   8'h0C
`define BXA_OFF_OPND_B   8'h10
`define BXA_OFF_IDX_A    8'h14
`define BXA_OFF_IDX_B    8'h18
`define BXA_OFF_RESULT   8'h1C
`define BXA_OFF_DISP     8'h20
`define BXA_OFF_RF_ADDR  8'h24
`define BXA_OFF_RF_DATA  8'h28

// ==========================================================
// Field positions
`define BXA_CTRL_SAT     0
`define BXA_ST_C         0
`define BXA_ST_V         1
`define BXA_ST_Z         2
`define BXA_ST_N         3
`define BXA_ST_UNF       4
`define BXA_ST_LOVF      5
`define BXA_ST_LUNF      6
`define BXA_ST_ERR       8
`define BXA_IN_FORM      0
`define BXA_IN_MODE      1
`define BXA_IN_TYPE      3
`define BXA_IN_DST       5
`define BXA_IN_SRC1      10
`define BXA_IN_SRC2      15
`define BXA_IN_DSEL      20
`define BXA_TYPE_S1_IND  0
`define BXA_TYPE_S2_IND  1

// ==========================================================
// Codes and reset values
`define BXA_MODE_REG     2'h0
`define BXA_MODE_DIR     2'h1
`define BXA_MODE_IND     2'h2
`define BXA_MODE_IMM     2'h3
`define BXA_DSEL_ZERO    2'h0
`define BXA_DSEL_ONE     2'h1
`define BXA_DSEL_IDXA    2'h2
`define BXA_RST_WORD     32'h0000_0000
`define BXA_EXEC_CYCLES  1

`endif

// >>> rtl/bxa_pkg.sv
// Types for the exclusive-OR execution block
`default_nettype none
package bxa_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_RDOUT} bxa_state_t;
endpackage : bxa_pkg
`default_nettype wire

// >>> rtl/bxa_rf_if.sv
// Register file port bundle between datapath and storage
`default_nettype none
interface bxa_rf_if #(
    parameter int AW = 5,
    parameter int DW = 32
);
    logic [AW-1:0] rd_a_addr;
    logic [AW-1:0] rd_b_addr;
    logic [DW-1:0] rd_a_data;
    logic [DW-1:0] rd_b_data;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;

    modport ctrl (output rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data,
                  input  rd_a_data, rd_b_data);
    modport mem  (input  rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data,
                  output rd_a_data, rd_b_data);
endinterface : bxa_rf_if
`default_nettype wire

// >>> rtl/bxa_regfile.sv
// Two-read one-write register file with registered read data
`default_nettype none
module bxa_regfile #(
    parameter int NREG = 28,
    parameter int AW   = 5,
    parameter int DW   = 32
) (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    bxa_rf_if.mem     rf
);
    logic [DW-1:0] mem_ff [NREG];
    logic [DW-1:0] nxt_rd_a;
    logic [DW-1:0] nxt_rd_b;
    logic [DW-1:0] rd_a_ff;
    logic [DW-1:0] rd_b_ff;

    // ==========================================================
    // Read side: out-of-range index reads zero
    always_comb
    begin
        nxt_rd_a = {DW{1'b0}};
        nxt_rd_b = {DW{1'b0}};
        if (int'(rf.rd_a_addr) < NREG)
            nxt_rd_a = mem_ff[rf.rd_a_addr];
        if (int'(rf.rd_b_addr) < NREG)
            nxt_rd_b = mem_ff[rf.rd_b_addr];
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            rd_a_ff <= {DW{1'b0}};
            rd_b_ff <= {DW{1'b0}};
        end
        else
        begin
            rd_a_ff <= nxt_rd_a;
            rd_b_ff <= nxt_rd_b;
        end
    end

    // ==========================================================
    // Write side: storage keeps no reset value
    always_ff @(posedge mclk_i)
    begin
        if (rf.wr_en && int'(rf.wr_addr) < NREG)
            mem_ff[rf.wr_addr] <= rf.wr_data;
    end

    assign rf.rd_a_data = rd_a_ff;
    assign rf.rd_b_data = rd_b_ff;
endmodule : bxa_regfile
`default_nettype wire

// >>> test/bxa_ahb_master.sv
// Bus master model issuing single word transfers
`default_nettype none
module bxa_ahb_master (
    input  wire logic        mclk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        hsel_o   = 1'b0;
        haddr_o  = 32'h0000_0000;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o  = 3'h2;
        hwdata_o = 32'h0000_0000;
    end

    // ==========================================================
    // One transfer; waits as long as the slave stalls
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel_o   <= 1'b1;
        htrans_o <= 2'h2;
        haddr_o  <= a;
        hwrite_o <= wr;
        hsize_o  <= 3'h2;
        @(posedge mclk_i);
        while (hready_i !== 1'b1) @(posedge mclk_i);
        htrans_o <= 2'h0;
        hwdata_o <= wr ? d : ~d;
        @(posedge mclk_i);
        while (hready_i !== 1'b1) @(posedge mclk_i);
        q = hrdata_i;
        // Stale write data must not linger
        hwdata_o <= ~hwdata_o;
    endtask : xfer
endmodule : bxa_ahb_master
`default_nettype wire

// >>> test/bxa_xor_alu_tb_top.sv
// Testbench for the exclusive-OR execution block
`include "bxa_consts.svh"
`default_nettype none
module bxa_xor_alu_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] R1V = 32'h000F_FA32;
    localparam logic [31:0] R2V = 32'h000F_F5C1;
    localparam logic [31:0] R3V = 32'hA5A5_0F0F;
    localparam logic [31:0] R4V = 32'h5A5A_FFFF;
    localparam logic [31:0] OPA = 32'h8765_C321;
    localparam logic [31:0] OPB = 32'hFFFF_0000;
    localparam logic [31:0] IXA = 32'h0000_0010;
    localparam logic [31:0] IXB = 32'h0000_0020;
    logic        mclk;
    logic        rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [31:0] e;
    logic [31:0] s;
    int          errors;
    int          n_tests;

    bxa_xor_alu i_dut (.mclk_i(mclk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp));
    bxa_ahb_master i_bus (.mclk_i(mclk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ==========================================================
    // Access helpers
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_bus.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic chk(input logic [31:0] a, input logic [31:0] x);
        logic [31:0] q;
        i_bus.xfer(1'b0, a, 32'h0000_0000, q);
        n_tests++;
        if (q !== x || hresp !== 1'b0)
        begin
            errors++;
            $display("ERROR %0t read %h got %h exp %h", $time, a, q, x);
        end
    endtask : chk

    task automatic setr(input logic [4:0] i, input logic [31:0] v);
        wr(`BXA_OFF_RF_ADDR, 32'(i));
        wr(`BXA_OFF_RF_DATA, v);
    endtask : setr

    task automatic chkr(input logic [4:0] i, input logic [31:0] x);
        wr(`BXA_OFF_RF_ADDR, 32'(i));
        chk(`BXA_OFF_RF_DATA, x);
    endtask : chkr

    function automatic logic [31:0] ins(input logic f, input logic [1:0] m, input logic [1:0] t,
        input logic [4:0] dst, input logic [4:0] s1, input logic [4:0] s2, input logic [1:0] ds);
        return {10'h000, ds, s2, s1, dst, t, m, f};
    endfunction : ins

    // Flags after an accepted XOR: carry, latched flags and error kept
    function automatic logic [31:0] fl(input logic [31:0] st, input logic [31:0] r);
        return (st & 32'h0000_0161) | {28'h000_0000, r[31], r == 32'h0000_0000, 2'h0};
    endfunction : fl

    task automatic test_done();
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    initial
    begin
        #200000;
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        test_done();
    end

    // ==========================================================
    // Test sequence
    initial
    begin
        errors = 0;
        n_tests = 0;
        rstn = 1'b0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk(`BXA_OFF_STATUS, 32'h0000_0000);
        chk(`BXA_OFF_RESULT, 32'h0000_0000);
        wr(32'h0000_0100, 32'hFFFF_FFFF);
        chk(32'h0000_0100, 32'h0000_0000);
        setr(5'h01, R1V);
        setr(5'h03, R3V);
        setr(5'h04, R4V);
        wr(`BXA_OFF_OPND_A, OPA);
        wr(`BXA_OFF_OPND_B, OPB);
        wr(`BXA_OFF_IDX_A, IXA);
        wr(`BXA_OFF_IDX_B, IXB);
        for (int m = 0; m < 4; m++)
        begin
            s = (m == 0) ? R1V : (m == 3) ? {16'h0000, OPA[15:0]} : OPA;
            e = s ^ R2V;
            setr(5'h02, R2V);
            wr(`BXA_OFF_STATUS, 32'h0000_0073);
            wr(`BXA_OFF_INSTR, ins(1'b0, 2'(m), 2'h0, 5'h02, 5'h01, 5'h00, 2'h0));
            chkr(5'h02, e);
            chk(`BXA_OFF_RESULT, e);
            chk(`BXA_OFF_STATUS, fl(32'h0000_0073, e));
        end
        for (int t = 0; t < 4; t++)
        begin
            e = ((t & 1) != 0 ? OPA : R3V) ^ ((t & 2) != 0 ? OPB : R4V);
            wr(`BXA_OFF_CTRL, 32'(t >> 1));
            wr(`BXA_OFF_STATUS, 32'h0000_0073);
            wr(`BXA_OFF_INSTR, ins(1'b1, 2'h0, 2'(t), 5'h1B, 5'h03, 5'h04, 2'h0));
            chkr(5'h1B, e);
            chkr(5'h03, R3V);
            chkr(5'h04, R4V);
            chk(`BXA_OFF_STATUS, fl(32'h0000_0073, e));
        end
        for (int d = 0; d < 4; d++)
        begin
            s = (d == 0) ? 32'h0000_0000 : (d == 1) ? 32'h0000_0001 : (d == 2) ? IXA : IXB;
            wr(`BXA_OFF_INSTR, ins(1'b1, 2'h0, 2'h3, 5'h05, 5'h03, 5'h04, 2'(d)));
            chk(`BXA_OFF_DISP, s);
        end
        wr(`BXA_OFF_STATUS, 32'h0000_007F);
        wr(`BXA_OFF_INSTR, ins(1'b1, 2'h0, 2'h0, 5'h06, 5'h03, 5'h03, 2'h0));
        chkr(5'h06, 32'h0000_0000);
        chk(`BXA_OFF_STATUS, fl(32'h0000_007F, 32'h0000_0000));
        wr(`BXA_OFF_STATUS, 32'h0000_0000);
        setr(5'h07, R2V);
        wr(`BXA_OFF_INSTR, ins(1'b1, 2'h0, 2'h0, 5'h07, 5'h1C, 5'h03, 2'h0));
        chkr(5'h07, R2V);
        chk(`BXA_OFF_STATUS, 32'h0000_0100);
        test_done();
    end
endmodule : bxa_xor_alu_tb_top
`default_nettype wire
